// File: core/gpib_defs.svh
// Constants for the GPIB remote/local state logic: offsets, fields, codes.
// Assumes inclusion by bare name from files under core/.
//
// Functional notes
// - Remote is entered only when addressed to listen while remote enable is asserted.
// - In remote only the return key and the output disable key work; local without lockout restores the panel.
// - Own talk address makes the device talker; untalk, own listen address or clear idles it.
// - Own listen address makes the device listener; unlisten, own talk address or clear idles it.
// - Service request stays until the poll byte is read or its cause is gone.
// - The return key, without lockout, leaves remote and restores the display.
// - Lockout disables every key but output disable until go-to-local or power-up.
// - Interface clear gives local, talker idle and listener idle, keeping settings and events.
// - Device clear empties buffers, cancels deferred commands and keeps settings.
// - Universal device clear acts whether or not the device is addressed.
// - Selective device clear acts only when the device is addressed.
// - Group execute trigger is an arm event for the trigger logic only when the device is addressed to listen.
// - The status byte, with bit 6 replaced by the live request, is returned on every serial poll, with or without a request.
// - Only the configured primary address 0 to 30 is answered; it resets to 15.
`ifndef GPIB_DEFS_SVH
`define GPIB_DEFS_SVH

`define ADDR_DEFAULT 5'h0f
`define ADDR_MAX 5'h1e
`define IFC_MIN_US 100

`define OFS_CONFIG 8'h00
`define OFS_STATE 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c

`define KEY_RETURN 0
`define KEY_OUT_OFF 1

`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_GET 7'h08
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_UNL 7'h3f
`define CMD_UNT 7'h5f
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2

`define RSV_BIT 6

`endif

// File: core/gpib_pkg.sv
// Types shared by the GPIB state logic and its decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package gpib_pkg;

    typedef struct packed {
        logic mla;
        logic mta;
        logic ota;
        logic unl;
        logic unt;
        logic llo;
        logic gtl;
        logic dcl;
        logic sdc;
        logic get;
        logic spe;
        logic spd;
    } cmd_t;

    typedef struct packed {
        logic [7:0] dio_n;
        logic dav_n;
        logic nrfd_n;
        logic ndac_n;
        logic atn_n;
        logic ren_n;
        logic ifc_n;
    } bus_in_t;

    typedef enum logic [1:0] {
        AH_IDLE = 2'b00,
        AH_READY = 2'b01,
        AH_HOLD = 2'b10
    } ah_state_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_SETUP = 2'b01,
        SH_VALID = 2'b10,
        SH_DONE = 2'b11
    } sh_state_t;

endpackage : gpib_pkg

// File: core/bus_sync.sv
// Two-stage synchroniser for a bundle of asynchronous bus pins.
// Assumes each bit is an independent level.
`timescale 1ns/1ns
`default_nettype none

module bus_sync #(
    parameter int W = 14
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            // Reset to the released (high) line level.
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    meta_reg <= 1'b1;
                    sync_reg <= 1'b1;
                end else begin
                    meta_reg <= d[i];
                    sync_reg <= meta_reg;
                end
            end
            assign q[i] = sync_reg;
        end
    endgenerate

endmodule : bus_sync

`default_nettype wire

// File: core/cmd_decode.sv
// Decoder of one interface command byte, taken with attention asserted.
// Assumes the byte is already inverted to positive logic.
`timescale 1ns/1ns
`default_nettype none
`include "gpib_defs.svh"

module cmd_decode
    import gpib_pkg::*;
(
    input wire logic [6:0] cmd_byte,
    input wire logic [4:0] my_addr,
    output cmd_t cmd
);

    logic [1:0] grp;
    logic addr_hit;

    assign grp = cmd_byte[6:5];
    // Address 31 is the unlisten/untalk code, never a device address.
    assign addr_hit = (cmd_byte[4:0] == my_addr) && (cmd_byte[4:0] != 5'h1f);

    always_comb begin
        cmd = '0;
        cmd.mla = (grp == `GRP_LISTEN) && addr_hit;
        cmd.mta = (grp == `GRP_TALK) && addr_hit;
        cmd.ota = (grp == `GRP_TALK) && !addr_hit && (cmd_byte != `CMD_UNT);
        cmd.unl = (cmd_byte == `CMD_UNL);
        cmd.unt = (cmd_byte == `CMD_UNT);
        cmd.llo = (cmd_byte == `CMD_LLO);
        cmd.gtl = (cmd_byte == `CMD_GTL);
        cmd.dcl = (cmd_byte == `CMD_DCL);
        cmd.sdc = (cmd_byte == `CMD_SDC);
        cmd.get = (cmd_byte == `CMD_GET);
        cmd.spe = (cmd_byte == `CMD_SPE);
        cmd.spd = (cmd_byte == `CMD_SPD);
    end

endmodule : cmd_decode

`default_nettype wire

// File: core/gpib_state_logic.sv
// GPIB remote/local, talker/listener, service request and serial poll logic.
// Assumes active-low pins, open-drain drivers built from the enables,
// and keys and service condition on sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "gpib_defs.svh"

module gpib_state_logic
    import gpib_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] dio_n_in,
    input wire logic dav_n_in,
    input wire logic nrfd_n_in,
    input wire logic ndac_n_in,
    input wire logic atn_n_in,
    input wire logic ren_n_in,
    input wire logic ifc_n_in,
    output logic [7:0] dio_n_out,
    output logic [7:0] dio_oe_n,
    output logic dav_n_out,
    output logic dav_oe_n,
    output logic nrfd_n_out,
    output logic nrfd_oe_n,
    output logic ndac_n_out,
    output logic ndac_oe_n,
    output logic srq_n_out,
    output logic srq_oe_n,
    input wire logic [7:0] key_press,
    input wire logic service_cond,
    input wire logic [7:0] status_byte,
    output logic [7:0] key_accept,
    output logic display_restore,
    output logic device_clear,
    output logic trigger_arm,
    output logic host_control_lamp,
    output logic talk_lamp,
    output logic receiver_lamp,
    output logic srq_lamp,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq
);

    bus_in_t bi;
    cmd_t cmd;

    bus_sync #(.W(14)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({dio_n_in, dav_n_in, nrfd_n_in, ndac_n_in, atn_n_in, ren_n_in, ifc_n_in}),
        .q(bi)
    );

    logic [4:0] addr_reg;
    logic [4:0] addr_next;

    cmd_decode u_decode (
        .cmd_byte(~bi.dio_n[6:0]),
        .my_addr(addr_reg),
        .cmd(cmd)
    );

    // Protocol state.
    logic remote_reg, remote_next;
    logic lockout_reg, lockout_next;
    logic tacs_reg, tacs_next;
    logic lacs_reg, lacs_next;
    logic spms_reg, spms_next;
    logic srq_reg, srq_next;
    logic svc_prev_reg, svc_prev_next;
    logic ifc_prev_reg, ifc_prev_next;
    logic [7:0] key_accept_next;
    logic display_restore_next, device_clear_next, trigger_arm_next;

    // Handshake state.
    ah_state_t ah_reg, ah_next;
    sh_state_t sh_reg, sh_next;
    logic [7:0] poll_reg, poll_next;
    logic [7:0] dio_oe_n_next;
    logic dav_oe_n_next, nrfd_oe_n_next, ndac_oe_n_next;
    logic capture, poll_done, cmd_go, participate, talk_poll;

    // Register file state.
    logic [5:0] irq_stat_reg, irq_stat_next;
    logic [5:0] irq_mask_reg, irq_mask_next;
    logic [7:0] reg_rdata_next;
    logic irq_next;
    logic [5:0] irq_set;

    logic ifc_act, ren_act;
    assign ifc_act = !bi.ifc_n;
    assign ren_act = !bi.ren_n;
    assign cmd_go = capture && !bi.atn_n;

    // Acceptor and source handshakes.
    always_comb begin
        ah_next = ah_reg;
        sh_next = sh_reg;
        poll_next = poll_reg;
        capture = 1'b0;
        poll_done = 1'b0;
        // Commands are taken by every device; data only by a listener.
        participate = !bi.atn_n || lacs_reg;
        talk_poll = tacs_reg && spms_reg && bi.atn_n && !ifc_act;
        case (ah_reg)
            AH_IDLE: begin
                if (participate) begin
                    ah_next = AH_READY;
                end
            end
            AH_READY: begin
                if (!participate) begin
                    ah_next = AH_IDLE;
                end else if (!bi.dav_n) begin
                    capture = 1'b1;
                    ah_next = AH_HOLD;
                end
            end
            AH_HOLD: begin
                if (bi.dav_n) begin
                    ah_next = participate ? AH_READY : AH_IDLE;
                end
            end
            default: ah_next = AH_IDLE;
        endcase
        case (sh_reg)
            SH_IDLE: begin
                if (talk_poll) begin
                    // Service bit carries the live request.
                    poll_next = {status_byte[7], srq_reg, status_byte[5:0]};
                    sh_next = SH_SETUP;
                end
            end
            SH_SETUP: begin
                if (!talk_poll) begin
                    sh_next = SH_IDLE;
                end else if (bi.nrfd_n) begin
                    sh_next = SH_VALID;
                end
            end
            SH_VALID: begin
                if (!talk_poll) begin
                    sh_next = SH_IDLE;
                end else if (bi.ndac_n) begin
                    poll_done = 1'b1;
                    sh_next = SH_DONE;
                end
            end
            SH_DONE: begin
                if (!talk_poll) begin
                    sh_next = SH_IDLE;
                end
            end
            default: sh_next = SH_IDLE;
        endcase
        dio_oe_n_next = 8'hff;
        if (sh_next == SH_SETUP || sh_next == SH_VALID) begin
            dio_oe_n_next = ~poll_next;
        end
        dav_oe_n_next = !(sh_next == SH_VALID);
        nrfd_oe_n_next = !(ah_next == AH_HOLD);
        ndac_oe_n_next = !(ah_next == AH_READY);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ah_reg <= AH_IDLE;
            sh_reg <= SH_IDLE;
            poll_reg <= 8'h00;
            dio_oe_n <= 8'hff;
            dav_oe_n <= 1'b1;
            nrfd_oe_n <= 1'b1;
            ndac_oe_n <= 1'b1;
        end else begin
            ah_reg <= ah_next;
            sh_reg <= sh_next;
            poll_reg <= poll_next;
            dio_oe_n <= dio_oe_n_next;
            dav_oe_n <= dav_oe_n_next;
            nrfd_oe_n <= nrfd_oe_n_next;
            ndac_oe_n <= ndac_oe_n_next;
        end
    end

    // Remote/local, addressing, clears, trigger and service request.
    always_comb begin
        remote_next = remote_reg;
        lockout_next = lockout_reg;
        tacs_next = tacs_reg;
        lacs_next = lacs_reg;
        spms_next = spms_reg;
        display_restore_next = 1'b0;
        device_clear_next = 1'b0;
        trigger_arm_next = 1'b0;
        svc_prev_next = service_cond;
        ifc_prev_next = ifc_act;
        if (cmd_go) begin
            if (cmd.mla) begin
                lacs_next = 1'b1;
                tacs_next = 1'b0;
                if (ren_act) begin
                    remote_next = 1'b1;
                end
            end
            if (cmd.mta) begin
                tacs_next = 1'b1;
                lacs_next = 1'b0;
            end
            if (cmd.ota || cmd.unt) begin
                tacs_next = 1'b0;
            end
            if (cmd.unl) begin
                lacs_next = 1'b0;
            end
            if (cmd.llo && ren_act) begin
                lockout_next = 1'b1;
            end
            if (cmd.gtl && lacs_reg) begin
                remote_next = 1'b0;
                lockout_next = 1'b0;
            end
            device_clear_next = cmd.dcl || (cmd.sdc && lacs_reg);
            trigger_arm_next = cmd.get && lacs_reg;
            if (cmd.spe) begin
                spms_next = 1'b1;
            end
            if (cmd.spd) begin
                spms_next = 1'b0;
            end
        end
        // Remote enable released always returns to local.
        if (!ren_act) begin
            remote_next = 1'b0;
        end
        if (key_press[`KEY_RETURN] && remote_reg && !lockout_reg) begin
            remote_next = 1'b0;
            display_restore_next = 1'b1;
        end
        // Interface clear overrides remote, talker, listener and poll mode changes of the same cycle.
        if (ifc_act) begin
            remote_next = 1'b0;
            tacs_next = 1'b0;
            lacs_next = 1'b0;
            spms_next = 1'b0;
        end
        // A new cause wins over a simultaneous poll read.
        if (service_cond && !svc_prev_reg) begin
            srq_next = 1'b1;
        end else if (poll_done || !service_cond) begin
            srq_next = 1'b0;
        end else begin
            srq_next = srq_reg;
        end
        for (int i = 0; i < 8; i++) begin
            key_accept_next[i] = key_press[i] && !remote_reg && !lockout_reg;
        end
        key_accept_next[`KEY_OUT_OFF] = key_press[`KEY_OUT_OFF];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            remote_reg <= 1'b0;
            lockout_reg <= 1'b0;
            tacs_reg <= 1'b0;
            lacs_reg <= 1'b0;
            spms_reg <= 1'b0;
            srq_reg <= 1'b0;
            svc_prev_reg <= 1'b0;
            ifc_prev_reg <= 1'b0;
            key_accept <= 8'h00;
            display_restore <= 1'b0;
            device_clear <= 1'b0;
            trigger_arm <= 1'b0;
        end else begin
            remote_reg <= remote_next;
            lockout_reg <= lockout_next;
            tacs_reg <= tacs_next;
            lacs_reg <= lacs_next;
            spms_reg <= spms_next;
            srq_reg <= srq_next;
            svc_prev_reg <= svc_prev_next;
            ifc_prev_reg <= ifc_prev_next;
            key_accept <= key_accept_next;
            display_restore <= display_restore_next;
            device_clear <= device_clear_next;
            trigger_arm <= trigger_arm_next;
        end
    end

    // Annunciators and open-drain lines come straight from flops.
    assign host_control_lamp = remote_reg;
    assign talk_lamp = tacs_reg;
    assign receiver_lamp = lacs_reg;
    assign srq_lamp = srq_reg;
    assign srq_oe_n = !srq_reg;
    assign dio_n_out = poll_reg & 8'h00;
    assign dav_n_out = !dav_oe_n & 1'b0;
    assign nrfd_n_out = dav_n_out;
    assign ndac_n_out = dav_n_out;
    assign srq_n_out = dav_n_out;

    // Registers: address, state view, sticky events, mask.
    always_comb begin
        irq_set = {poll_done,
                   lockout_next && !lockout_reg,
                   remote_next && !remote_reg,
                   trigger_arm_next,
                   device_clear_next,
                   ifc_act && !ifc_prev_reg};
        addr_next = addr_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        if (reg_wr && reg_addr == `OFS_CONFIG && reg_wdata[4:0] <= `ADDR_MAX) begin
            addr_next = reg_wdata[4:0];
        end
        if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
            irq_mask_next = reg_wdata[5:0];
        end
        if (reg_wr && reg_addr == `OFS_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~reg_wdata[5:0];
        end
        irq_stat_next = irq_stat_next | irq_set;
        irq_next = |(irq_stat_next & irq_mask_next);
        reg_rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `OFS_CONFIG: reg_rdata_next = {3'h0, addr_reg};
                `OFS_STATE: reg_rdata_next = {2'h0, srq_reg, spms_reg, lacs_reg,
                                              tacs_reg, lockout_reg, remote_reg};
                `OFS_IRQ_STAT: reg_rdata_next = {2'h0, irq_stat_reg};
                `OFS_IRQ_MASK: reg_rdata_next = {2'h0, irq_mask_reg};
                default: reg_rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr_reg <= `ADDR_DEFAULT;
            irq_stat_reg <= 6'h00;
            irq_mask_reg <= 6'h00;
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            reg_rdata <= reg_rdata_next;
            irq <= irq_next;
        end
    end

endmodule : gpib_state_logic

`default_nettype wire

// File: test/gpib_state_logic_asserts.sv
// Port checker for the GPIB state logic, bound into every instance.
// Assumes one clock sys_clk and async active-high rst.
`timescale 1ns/1ns
`default_nettype none

module gpib_state_logic_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ren_n_in,
    input wire logic ifc_n_in,
    input wire logic [7:0] key_press,
    input wire logic [7:0] key_accept,
    input wire logic service_cond,
    input wire logic srq_oe_n,
    input wire logic [7:0] dio_oe_n,
    input wire logic trigger_arm,
    input wire logic host_control_lamp,
    input wire logic talk_lamp,
    input wire logic receiver_lamp,
    input wire logic srq_lamp,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    remote_by_listen_a: assert property ($rose(host_control_lamp) |-> receiver_lamp)
        else $error("remote entered without listen address");
    ren_local_a: assert property (ren_n_in [*5] |-> !host_control_lamp)
        else $error("remote held without remote enable");
    key_block_a: assert property (
        host_control_lamp && $past(host_control_lamp) && key_press[2] |=> !key_accept[2])
        else $error("panel key passed in remote");
    out_off_a: assert property (key_press[1] |=> key_accept[1])
        else $error("output disable key dropped");
    role_excl_a: assert property (!(talk_lamp && receiver_lamp))
        else $error("talker and listener at once");
    ifc_idle_a: assert property (!ifc_n_in [*5] |-> !(talk_lamp || receiver_lamp || host_control_lamp))
        else $error("state kept through interface clear");
    srq_set_a: assert property ($rose(service_cond) |-> ##[1:3] srq_lamp)
        else $error("service request not raised");
    srq_drop_a: assert property (!service_cond [*3] |-> !srq_lamp)
        else $error("service request without cause");
    trig_listen_a: assert property (trigger_arm |-> receiver_lamp)
        else $error("trigger while not listener");
    poll_talk_a: assert property (dio_oe_n != 8'hff |-> talk_lamp)
        else $error("data driven while not talker");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer");

    cover property ($rose(host_control_lamp));
    cover property ($rose(talk_lamp));
    cover property ($fell(srq_lamp) && service_cond);
endmodule : gpib_state_logic_asserts

bind gpib_state_logic gpib_state_logic_asserts chk (.sys_clk, .rst, .ren_n_in, .ifc_n_in,
    .key_press, .key_accept, .service_cond, .srq_oe_n, .dio_oe_n, .trigger_arm,
    .host_control_lamp, .talk_lamp, .receiver_lamp, .srq_lamp, .reg_rd, .reg_rdata);

`default_nettype wire

// File: test/ctl_model.sv
// Controller model: sends command bytes and reads poll bytes.
// Assumes the bench resolves the open-drain lines and feeds them back.
`timescale 1ns/1ns
`default_nettype none
`include "gpib_defs.svh"

module ctl_model (
    input wire logic sys_clk,
    input wire logic [7:0] dio_n,
    input wire logic dav_n,
    input wire logic nrfd_n,
    input wire logic ndac_n,
    output logic [7:0] c_dio_n,
    output logic c_dav_n,
    output logic c_nrfd_n,
    output logic c_ndac_n,
    output logic c_atn_n,
    output logic c_ren_n,
    output logic c_ifc_n
);
    // Released lines sit at the pull-up level.
    initial begin
        c_dio_n = 8'hff;
        {c_dav_n, c_nrfd_n, c_ndac_n, c_atn_n, c_ren_n, c_ifc_n} = 6'h3f;
    end

    // Select 0 is ready-for-data, 1 is data-accepted, 2 is data-valid.
    task automatic wait_lvl(input int s, input logic v);
        logic [2:0] l;
        for (int n = 0; n < 200; n++) begin
            @(posedge sys_clk);
            #1;
            l = {dav_n, ndac_n, nrfd_n};
            if (l[s] === v)
                return;
        end
        tb.hang();
    endtask : wait_lvl

    task automatic send(input logic [7:0] b);
        wait_lvl(0, 1'b1);
        @(posedge sys_clk);
        c_dio_n <= ~b;
        // Data settle one cycle before valid.
        @(posedge sys_clk);
        c_dav_n <= 1'b0;
        wait_lvl(1, 1'b1);
        @(posedge sys_clk);
        c_dav_n <= 1'b1;
        c_dio_n <= 8'hff;
        wait_lvl(1, 1'b0);
    endtask : send

    task automatic poll(output logic [7:0] b);
        @(posedge sys_clk);
        c_atn_n <= 1'b1;
        c_ndac_n <= 1'b0;
        c_nrfd_n <= 1'b0;
        @(posedge sys_clk);
        c_nrfd_n <= 1'b1;
        wait_lvl(2, 1'b0);
        b = ~dio_n;
        @(posedge sys_clk);
        c_nrfd_n <= 1'b0;
        c_ndac_n <= 1'b1;
        wait_lvl(2, 1'b1);
        @(posedge sys_clk);
        c_nrfd_n <= 1'b1;
        c_atn_n <= 1'b0;
    endtask : poll

    task automatic ifc();
        @(posedge sys_clk);
        c_ifc_n <= 1'b0;
        repeat (`IFC_MIN_US * 50) @(posedge sys_clk);
        c_ifc_n <= 1'b1;
    endtask : ifc
endmodule : ctl_model

`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the GPIB state logic with a controller model.
// Assumes design, checker and model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam logic [7:0] MY = 8'h1e;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, service_cond = 1'b0;
    logic [7:0] key_press = 8'h00, status_byte = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [7:0] dio_oe_n, key_accept, reg_rdata, c_dio_n, d;
    logic dav_oe_n, nrfd_oe_n, ndac_oe_n, srq_oe_n, display_restore, device_clear, trigger_arm;
    logic c_dav_n, c_nrfd_n, c_ndac_n, c_atn_n, c_ren_n, c_ifc_n, irq;
    logic host_control_lamp, talk_lamp, receiver_lamp, srq_lamp;
    int err_count = 0, cmp_count = 0;
    int n_clr = 0, n_trg = 0, n_disp = 0, p;
    wire [7:0] dio_w = c_dio_n & dio_oe_n;
    wire dav_w = c_dav_n & dav_oe_n;
    wire nrfd_w = c_nrfd_n & nrfd_oe_n;
    wire ndac_w = c_ndac_n & ndac_oe_n;

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // Pulses are counted, so checks need not land in their one cycle.
    always @(posedge sys_clk) begin
        if (device_clear === 1'b1)
            n_clr <= n_clr + 1;
        if (trigger_arm === 1'b1)
            n_trg <= n_trg + 1;
        if (display_restore === 1'b1)
            n_disp <= n_disp + 1;
    end

    gpib_state_logic dut (
        .sys_clk, .rst, .dio_n_in(dio_w), .dav_n_in(dav_w), .nrfd_n_in(nrfd_w),
        .ndac_n_in(ndac_w), .atn_n_in(c_atn_n), .ren_n_in(c_ren_n), .ifc_n_in(c_ifc_n),
        .dio_n_out(), .dio_oe_n, .dav_n_out(), .dav_oe_n, .nrfd_n_out(), .nrfd_oe_n,
        .ndac_n_out(), .ndac_oe_n, .srq_n_out(), .srq_oe_n, .key_press, .service_cond,
        .status_byte, .key_accept, .display_restore, .device_clear, .trigger_arm,
        .host_control_lamp, .talk_lamp, .receiver_lamp, .srq_lamp, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq
    );
    ctl_model ctl (
        .sys_clk, .dio_n(dio_w), .dav_n(dav_w), .nrfd_n(nrfd_w), .ndac_n(ndac_w), .c_dio_n,
        .c_dav_n, .c_nrfd_n, .c_ndac_n, .c_atn_n, .c_ren_n, .c_ifc_n
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic hang();
        err_count++;
        $display("ERROR %0t wait timeout", $time);
        final_report();
    endtask : hang

    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic key(input logic [7:0] k, input logic [7:0] exp);
        @(posedge sys_clk);
        key_press <= k;
        @(posedge sys_clk);
        key_press <= 8'h00;
        #1;
        chk(key_accept, exp);
        settle();
    endtask : key

    task automatic cmd(input logic [7:0] b);
        @(posedge sys_clk);
        ctl.c_atn_n <= 1'b0;
        ctl.send(b);
    endtask : cmd

    task automatic t_regs();
        rd(8'h00, 8'h0f);
        wr(8'h00, 8'h1f);
        rd(8'h00, 8'h0f);
        wr(8'h00, MY);
        rd(8'h00, MY);
        rd(8'h10, 8'h00);
        rd(8'h04, 8'h00);
        $display("registers done");
    endtask : t_regs

    task automatic t_remote();
        ctl.c_ren_n <= 1'b0;
        settle();
        chk(host_control_lamp, 0);
        key(8'h04, 8'h04);
        cmd(8'h3d);
        chk(host_control_lamp, 0);
        cmd(8'h3e);
        chk({host_control_lamp, receiver_lamp}, 8'h03);
        key(8'h04, 8'h00);
        key(8'h02, 8'h02);
        p = n_disp;
        key(8'h01, 8'h00);
        chk(host_control_lamp, 0);
        chk(8'(n_disp - p), 8'h01);
        key(8'h04, 8'h04);
        $display("remote done");
    endtask : t_remote

    task automatic t_lock();
        cmd(8'h11);
        cmd(8'h3e);
        p = n_disp;
        key(8'h01, 8'h00);
        chk(host_control_lamp, 1);
        chk(8'(n_disp - p), 8'h00);
        key(8'h02, 8'h02);
        cmd(8'h01);
        chk(host_control_lamp, 0);
        key(8'h04, 8'h04);
        $display("lockout done");
    endtask : t_lock

    task automatic t_roles();
        cmd(8'h5e);
        chk({talk_lamp, receiver_lamp}, 8'h02);
        cmd(8'h3e);
        chk({talk_lamp, receiver_lamp}, 8'h01);
        cmd(8'h3f);
        chk({talk_lamp, receiver_lamp}, 8'h00);
        cmd(8'h5e);
        cmd(8'h5f);
        chk({talk_lamp, receiver_lamp}, 8'h00);
        $display("roles done");
    endtask : t_roles

    task automatic t_ifc();
        cmd(8'h3e);
        wr(8'h0c, 8'h01);
        ctl.ifc();
        settle();
        chk({host_control_lamp, talk_lamp, receiver_lamp}, 8'h00);
        chk(irq, 1);
        rd(8'h00, MY);
        wr(8'h08, 8'hff);
        settle();
        chk(irq, 0);
        $display("clear line done");
    endtask : t_ifc

    task automatic t_clear();
        p = n_clr;
        cmd(8'h14);
        chk(8'(n_clr - p), 8'h01);
        cmd(8'h04);
        chk(8'(n_clr - p), 8'h01);
        cmd(8'h3e);
        cmd(8'h04);
        chk(8'(n_clr - p), 8'h02);
        p = n_trg;
        cmd(8'h08);
        chk(8'(n_trg - p), 8'h01);
        $display("device clear done");
    endtask : t_clear

    task automatic t_poll();
        status_byte <= 8'ha5;
        service_cond <= 1'b1;
        settle();
        chk({srq_lamp, srq_oe_n}, 8'h02);
        cmd(8'h18);
        cmd(8'h5e);
        ctl.poll(d);
        chk(d, 8'he5);
        settle();
        chk(srq_lamp, 0);
        cmd(8'h19);
        cmd(8'h5f);
        status_byte <= 8'h40;
        cmd(8'h18);
        cmd(8'h5e);
        ctl.poll(d);
        chk(d, 8'h00);
        cmd(8'h19);
        cmd(8'h5f);
        service_cond <= 1'b0;
        settle();
        service_cond <= 1'b1;
        settle();
        chk(srq_lamp, 1);
        service_cond <= 1'b0;
        settle();
        chk(srq_lamp, 0);
        $display("serial poll done");
    endtask : t_poll

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_remote();
        t_lock();
        t_roles();
        t_ifc();
        t_clear();
        t_poll();
        final_report();
    end
endmodule : tb

`default_nettype wire
